// ### rtl/ccd_pkg.sv
package ccd_pkg;

    // ************************************************************
    // Code tables and widths
    // ************************************************************
    localparam int DIGITS = 10;
    localparam int WORD_W = 8;
    // Shift register: sentinel, word, parity bit, leading pad
    localparam int SR_W = WORD_W + 3;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] PUSH_FIRST = 4'h1;
    localparam logic [CNT_W-1:0] PUSH_LAST = 4'h9;
    localparam logic [3:0] XS3_OFS = 4'h3;
    localparam logic [3:0] XS3_MIN = 4'h3;
    localparam logic [3:0] XS3_MAX = 4'hc;
    localparam logic [3:0] BCD_MAX = 4'h9;

    localparam logic [3:0] GRAY10_TAB [DIGITS] = '{
        4'h2, 4'h6, 4'h7, 4'h5, 4'h4, 4'hc, 4'hd, 4'hf, 4'he, 4'ha};
    localparam logic [3:0] B1242_TAB [DIGITS] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    localparam logic [3:0] AIKEN_TAB [DIGITS] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    localparam logic [4:0] JOHN_TAB [DIGITS] = '{
        5'h00, 5'h01, 5'h03, 5'h07, 5'h0f,
        5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10};

    // ************************************************************
    // Parity checker states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_LOAD = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } ccd_state_t;

endpackage

// ### rtl/ccd_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - BCD decoder pulls low only the output equal to its 8421 value.
// - BCD inputs 1010 to 1111 are don't-care for the decoder.
// - Excess-three decoder pulls low the output of code minus three.
// - Ten-state Gray decoder maps its ten codes to digits 0 to 9.
// - Johnson decoder uses two bits per digit: A,E ends and boundaries.
// - 1242 encoder gives binary for 0-3, then 1010 to 1111.
// - Aiken encoder gives binary for 0-4, then 1011 to 1111.
// - Excess-three encoder outputs digit plus three.
// - Johnson encoder fills ones from A upward, then clears from A.
// - Johnson transcoder turns each valid state into its 8421 digit.
// - Ten-state Gray transcoder gives the BCD of the code's position.
// - Sixteen-state Gray transcoder gives the binary position.
// - BCD error flag is D and (B or C).
// - Excess-three error flag for 0000-0010 and 1101-1111 only.
// - Parity bit is high for an even count of ones in the word.
// - Odd count of ones in word plus parity means error.
// - Toggle flop sits preset high until the check starts.
// - Control high loads the word in parallel; low shifts it out.
// - Toggle flips on each shift with final stage low; drives ok output.
// - Shifting stops once the shift register holds all zeros.
module ccd_top
    import ccd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Decoders, detectors and transcoders
    input wire logic [3:0] bcd_i,
    input wire logic [3:0] xs3_i,
    input wire logic [3:0] gray10_i,
    input wire logic [4:0] john_i,
    input wire logic [3:0] aiken_i,
    input wire logic [3:0] gray16_i,
    output logic [DIGITS-1:0] bcd_dec_n_o,
    output logic [DIGITS-1:0] xs3_dec_n_o,
    output logic [DIGITS-1:0] gray_dec_n_o,
    output logic [DIGITS-1:0] john_dec_n_o,
    output logic [3:0] john_bcd_o,
    output logic [3:0] gray10_bcd_o,
    output logic [3:0] gray16_bin_o,
    output logic bcd_err_o,
    output logic xs3_err_o,
    output logic aiken_err_o,
    // Decimal encoders
    input wire logic [DIGITS-1:0] dec_n_i,
    output logic [3:0] enc_bcd_o,
    output logic [3:0] enc_1242_o,
    output logic [3:0] enc_aiken_o,
    output logic [3:0] enc_xs3_o,
    output logic [4:0] enc_john_o,
    // Parity checker, sending side
    input wire logic load_i,
    input wire logic [WORD_W-1:0] word_i,
    input wire logic par_i,
    output logic par_gen_o,
    output logic busy_o,
    output logic done_o,
    output logic ok_o,
    // Serial stream to the receiving register
    output logic ser_valid_o,
    output logic ser_data_o,
    input wire logic ser_ready_i
);

    // ************************************************************
    // Decoders, one output per digit
    // ************************************************************
    genvar d;
    generate
        for (d = 0; d < DIGITS; d++) begin : g_dig
            // Unused BCD states may light 8 or 9; they are don't-care
            assign bcd_dec_n_o[d] = (bcd_i[3] && d >= 8) ?
                (bcd_i[0] != 1'(d)) : (bcd_i != 4'(d));
            assign xs3_dec_n_o[d] =
                (xs3_i != 4'(d + XS3_OFS));
            assign gray_dec_n_o[d] = (gray10_i != GRAY10_TAB[d]);
            if (d == 0) begin : g_j0
                assign john_dec_n_o[d] = john_i[0] | john_i[4];
            end else if (d < 5) begin : g_jlo
                assign john_dec_n_o[d] = ~(john_i[d-1] & ~john_i[d]);
            end else if (d == 5) begin : g_j5
                assign john_dec_n_o[d] = ~(john_i[0] & john_i[4]);
            end else begin : g_jhi
                assign john_dec_n_o[d] = ~(~john_i[d-6] & john_i[d-5]);
            end
        end
    endgenerate

    // ************************************************************
    // Transcoders and redundant-state detectors
    // ************************************************************
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_gbin
            if (b == 3) begin : g_top
                assign gray16_bin_o[b] = gray16_i[b];
            end else begin : g_rest
                assign gray16_bin_o[b] = gray16_bin_o[b+1] ^ gray16_i[b];
            end
        end
    endgenerate

    always_comb begin
        john_bcd_o = 4'h0;
        gray10_bcd_o = 4'h0;
        for (int i = 0; i < DIGITS; i++) begin
            if (john_i == JOHN_TAB[i]) john_bcd_o = 4'(i);
            if (gray10_i == GRAY10_TAB[i]) gray10_bcd_o = 4'(i);
        end
    end

    assign bcd_err_o = bcd_i[3] & (bcd_i[2] | bcd_i[1]);
    assign xs3_err_o = (xs3_i < XS3_MIN) || (xs3_i > XS3_MAX);
    assign aiken_err_o = (aiken_i[0] & aiken_i[2] & ~aiken_i[3])
        | (~aiken_i[0] & ~aiken_i[2] & aiken_i[3])
        | (aiken_i[1] & aiken_i[2] & ~aiken_i[3])
        | (~aiken_i[1] & ~aiken_i[2] & aiken_i[3]);

    // ************************************************************
    // Encoders
    // ************************************************************
    // With no input low every code reads zero; several low inputs
    // OR their codes together, as the gate network would.
    always_comb begin
        enc_bcd_o = 4'h0;
        enc_1242_o = 4'h0;
        enc_aiken_o = 4'h0;
        enc_xs3_o = 4'h0;
        enc_john_o = 5'h00;
        for (int i = 0; i < DIGITS; i++) begin
            if (!dec_n_i[i]) begin
                enc_bcd_o = enc_bcd_o | 4'(i);
                enc_1242_o = enc_1242_o | B1242_TAB[i];
                enc_aiken_o = enc_aiken_o | AIKEN_TAB[i];
                enc_xs3_o = enc_xs3_o | 4'(i + XS3_OFS);
                enc_john_o = enc_john_o | JOHN_TAB[i];
            end
        end
    end

    // ************************************************************
    // Serial parity checker
    // ************************************************************
    ccd_state_t st_r, st_nxt;
    logic [SR_W-1:0] sr_r, sr_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic tog_r, tog_nxt;
    logic push;
    logic buf_in_rdy;

    assign par_gen_o = ~^word_i;

    always_comb begin
        st_nxt = st_r;
        sr_nxt = sr_r;
        cnt_nxt = cnt_r;
        tog_nxt = tog_r;
        push = 1'b0;
        case (st_r)
            ST_LOAD: begin
                // The high sentinel forces every bit out; the low pad makes
                // the toggle count come out to the word's parity
                tog_nxt = 1'b1;
                sr_nxt = {1'b1, word_i, par_i, 1'b0};
                cnt_nxt = '0;
                if (!load_i) st_nxt = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (load_i) begin
                    st_nxt = ST_LOAD;
                    tog_nxt = 1'b1;
                end else if (sr_r == '0) begin
                    st_nxt = ST_DONE;
                end else if (buf_in_rdy) begin
                    sr_nxt = sr_r >> 1;
                    cnt_nxt = cnt_r + 4'h1;
                    if (!sr_r[0]) tog_nxt = ~tog_r;
                    push = (cnt_r >= PUSH_FIRST) && (cnt_r <= PUSH_LAST);
                end
            end
            ST_DONE: begin
                tog_nxt = tog_r | load_i;
                if (load_i) st_nxt = ST_LOAD;
            end
            default: st_nxt = ST_LOAD;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_r <= ST_LOAD;
            sr_r <= '0;
            cnt_r <= '0;
            tog_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            sr_r <= sr_nxt;
            cnt_r <= cnt_nxt;
            tog_r <= tog_nxt;
        end
    end

    assign busy_o = (st_r == ST_SHIFT);
    assign done_o = (st_r == ST_DONE);
    assign ok_o = tog_r;

    // ************************************************************
    // Two-entry buffer toward the receiving register
    // ************************************************************
    // A stalled receiver freezes the shifting, so no bit is dropped.
    logic [1:0] mem_r, mem_nxt;
    logic [1:0] bcnt_r, bcnt_nxt;
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic pop;

    assign buf_in_rdy = (bcnt_r != 2'h2);
    assign pop = ser_valid_o && ser_ready_i;
    assign ser_valid_o = (bcnt_r != 2'h0);
    assign ser_data_o = mem_r[rp_r];

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        bcnt_nxt = bcnt_r;
        if (push) begin
            mem_nxt[wp_r] = sr_r[0];
            wp_nxt = ~wp_r;
        end
        if (pop) rp_nxt = ~rp_r;
        if (push && !pop) bcnt_nxt = bcnt_r + 2'h1;
        if (pop && !push) bcnt_nxt = bcnt_r - 2'h1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mem_r <= 2'h0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            bcnt_r <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            bcnt_r <= bcnt_nxt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [SR_W-1:0] ld_word_r;
    always_ff @(posedge sys_clk_i) begin
        if (st_r == ST_LOAD) ld_word_r <= sr_nxt;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_bcd_onehot: assert property (bcd_i <= BCD_MAX |->
        bcd_dec_n_o == ~(10'h001 << bcd_i))
        else $error("bcd decoder output wrong");
    a_bcd_dontcare: assert property (bcd_i > BCD_MAX |->
        $countones(~bcd_dec_n_o) <= 1)
        else $error("bcd decoder unused state lit two lines");
    a_xs3_onehot: assert property (!xs3_err_o |->
        xs3_dec_n_o == ~(10'h001 << 4'(xs3_i - XS3_OFS)))
        else $error("excess three decoder output wrong");
    a_gray_dec_map: assert property (gray_dec_n_o[gray10_bcd_o] == 1'b0
        || $countones(~gray_dec_n_o) == 0)
        else $error("gray decoder disagrees with transcoder");
    a_john_dec_map: assert property (john_i == JOHN_TAB[john_bcd_o] |->
        john_dec_n_o == ~(10'h001 << john_bcd_o))
        else $error("johnson decoder output wrong");
    a_enc_1242: assert property ($countones(~dec_n_i) == 1 |->
        enc_1242_o == B1242_TAB[enc_bcd_o])
        else $error("1242 encoder wrong");
    a_enc_aiken: assert property ($countones(~dec_n_i) == 1 |->
        enc_aiken_o == AIKEN_TAB[enc_bcd_o] && !aiken_err_o
            | (aiken_i != enc_aiken_o))
        else $error("aiken encoder wrong");
    a_enc_xs3: assert property ($countones(~dec_n_i) == 1 |->
        enc_xs3_o == enc_bcd_o + XS3_OFS)
        else $error("excess three encoder wrong");
    a_enc_john: assert property ($countones(~dec_n_i) == 1 |->
        enc_john_o == JOHN_TAB[enc_bcd_o]
        && dec_n_i[enc_bcd_o] == 1'b0)
        else $error("johnson encoder wrong");
    a_john_bcd: assert property (john_i == 5'h18 |->
        john_bcd_o == 4'h8)
        else $error("johnson transcoder wrong");
    a_gray10_bcd: assert property (gray10_i == 4'ha |->
        gray10_bcd_o == 4'h9)
        else $error("gray transcoder wrong");
    a_gray16_bin: assert property ((gray16_bin_o ^ (gray16_bin_o >> 1))
        == gray16_i)
        else $error("gray to binary wrong");
    a_bcd_err: assert property (bcd_err_o == (bcd_i > BCD_MAX))
        else $error("bcd error flag wrong");
    a_xs3_err: assert property (xs3_err_o == (xs3_i == 4'h0 ||
        xs3_i == 4'h1 || xs3_i == 4'h2 || xs3_i >= 4'hd))
        else $error("excess three error flag wrong");
    a_aiken_err: assert property (aiken_err_o ==
        (aiken_i >= 4'h5 && aiken_i <= 4'ha))
        else $error("aiken error flag wrong");
    a_par_gen: assert property (^{word_i, par_gen_o} == 1'b1)
        else $error("parity generator wrong");
    a_result: assert property (done_o && $rose(done_o) |->
        ok_o == ~^ld_word_r[SR_W-2:1])
        else $error("parity verdict wrong");
    a_preset_hold: assert property (load_i |=>
        tog_r && st_r == ST_LOAD)
        else $error("toggle not preset during load");
    a_load_shift: assert property (st_r == ST_LOAD && !load_i |=>
        busy_o && sr_r[SR_W-1] && !sr_r[0])
        else $error("parallel load wrong");
    a_toggle_low: assert property (busy_o && !load_i && sr_r != '0
        && buf_in_rdy && !sr_r[0] |=> tog_r != $past(tog_r))
        else $error("toggle missed a low stage");
    a_stop_zero: assert property (busy_o && sr_r == '0 && !load_i
        |=> done_o ##1 (done_o || st_r == ST_LOAD))
        else $error("shifting did not stop at zero");
    a_stall_hold: assert property (busy_o && !buf_in_rdy && !load_i
        |=> sr_r == $past(sr_r))
        else $error("shift advanced while stalled");

    c_check_ok: cover property ($rose(done_o) && ok_o);
    c_check_err: cover property ($rose(done_o) && !ok_o);
    c_stall: cover property ((busy_o && !buf_in_rdy) [*3]);
    c_reload: cover property (busy_o && load_i);

endmodule

// ### testbench/ccd_rx_model.sv
`timescale 1ns/100ps
// ************************************************************
// Receiving register: collects the checked bits, lsb first
// ************************************************************
module ccd_rx_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control: clear, and pace 0 fast, 1 slow, 2 hold off
    input wire logic clr_i,
    input wire logic [1:0] mode_i,
    // Serial stream from the checker
    input wire logic valid_i,
    input wire logic data_i,
    output logic ready_o,
    // Collected word and bit count
    output logic [8:0] word_o,
    output logic [3:0] cnt_o
);
    logic [1:0] phase_r;

    // Slow pace accepts one bit in three so the two-entry buffer fills
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            word_o <= 9'h000;
            cnt_o <= 4'h0;
        end else if (valid_i && ready_o) begin
            word_o <= {data_i, word_o[8:1]};
            cnt_o <= cnt_o + 4'h1;
        end
        phase_r <= (rst_i || phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
        ready_o <= !rst_i && (mode_i == 2'h0 ||
                              (mode_i == 2'h1 && phase_r == 2'h1));
    end
endmodule

// ### testbench/tb_ccd_top.sv
`timescale 1ns/100ps
module tb_ccd_top;
    import ccd_pkg::*;
    typedef struct packed {
        logic [3:0] g10;
        logic [4:0] jn;
        logic [3:0] c1242;
        logic [3:0] aik;
    } ccd_row_t;

    logic sys_clk_i = 1'b0;
    logic rst_i, load_i, par_i, ser_ready_i, ser_valid_o, ser_data_o;
    logic [3:0] bcd_i, xs3_i, gray10_i, aiken_i, gray16_i;
    logic [4:0] john_i, enc_john_o;
    logic [9:0] dec_n_i, bcd_dec_n_o, xs3_dec_n_o, gray_dec_n_o;
    logic [9:0] john_dec_n_o;
    logic [3:0] john_bcd_o, gray10_bcd_o, gray16_bin_o;
    logic [3:0] enc_bcd_o, enc_1242_o, enc_aiken_o, enc_xs3_o;
    logic bcd_err_o, xs3_err_o, aiken_err_o;
    logic par_gen_o, busy_o, done_o, ok_o, rx_clr;
    logic [7:0] word_i;
    logic [1:0] rx_mode;
    logic [8:0] rx_word;
    logic [3:0] rx_cnt, v;
    logic [9:0] exp_n;
    int n_errors = 0;
    int samples_checked = 0;
    ccd_row_t rows [10] = '{
        '{4'h2, 5'h00, 4'h0, 4'h0}, '{4'h6, 5'h01, 4'h1, 4'h1},
        '{4'h7, 5'h03, 4'h2, 4'h2}, '{4'h5, 5'h07, 4'h3, 4'h3},
        '{4'h4, 5'h0f, 4'ha, 4'h4}, '{4'hc, 5'h1f, 4'hb, 4'hb},
        '{4'hd, 5'h1e, 4'hc, 4'hc}, '{4'hf, 5'h1c, 4'hd, 4'hd},
        '{4'he, 5'h18, 4'he, 4'he}, '{4'ha, 5'h10, 4'hf, 4'hf}};

    always #12.5 sys_clk_i = ~sys_clk_i;

    ccd_top ccd_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bcd_i(bcd_i),
        .xs3_i(xs3_i), .gray10_i(gray10_i), .john_i(john_i),
        .aiken_i(aiken_i), .gray16_i(gray16_i), .bcd_dec_n_o(bcd_dec_n_o),
        .xs3_dec_n_o(xs3_dec_n_o), .gray_dec_n_o(gray_dec_n_o),
        .john_dec_n_o(john_dec_n_o), .john_bcd_o(john_bcd_o),
        .gray10_bcd_o(gray10_bcd_o), .gray16_bin_o(gray16_bin_o),
        .bcd_err_o(bcd_err_o), .xs3_err_o(xs3_err_o),
        .aiken_err_o(aiken_err_o), .dec_n_i(dec_n_i), .enc_bcd_o(enc_bcd_o),
        .enc_1242_o(enc_1242_o), .enc_aiken_o(enc_aiken_o),
        .enc_xs3_o(enc_xs3_o), .enc_john_o(enc_john_o), .load_i(load_i),
        .word_i(word_i), .par_i(par_i), .par_gen_o(par_gen_o),
        .busy_o(busy_o), .done_o(done_o), .ok_o(ok_o),
        .ser_valid_o(ser_valid_o), .ser_data_o(ser_data_o),
        .ser_ready_i(ser_ready_i));

    ccd_rx_model ccd_rx_model_i (.clk_i(sys_clk_i), .rst_i(rst_i),
        .clr_i(rx_clr), .mode_i(rx_mode), .valid_i(ser_valid_o),
        .data_i(ser_data_o), .ready_o(ser_ready_i), .word_o(rx_word),
        .cnt_o(rx_cnt));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ************************************************************
    // One parity check; the sender supplies the word and its bit
    // ************************************************************
    task automatic run_par(input logic [7:0] w, input logic p,
                           input logic [1:0] mode);
        int n;
        @(negedge sys_clk_i);
        rx_clr = 1'b1;
        rx_mode = mode;
        load_i = 1'b1;
        word_i = w;
        par_i = p;
        @(negedge sys_clk_i);
        rx_clr = 1'b0;
        check(64'(par_gen_o), 64'(~^w));
        check(64'({ok_o, done_o}), 64'(2'b10));
        load_i = 1'b0;
        n = 0;
        if (mode == 2'h2) begin
            repeat (20) @(negedge sys_clk_i);
            // Full buffer must hold the shifter, not drop bits
            check(64'({busy_o, done_o, ser_valid_o}), 64'(3'b101));
            rx_mode = 2'h0;
        end
        while (done_o !== 1'b1 && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (mode == 2'h0)
            check(64'(n), 64'(13));
        repeat (6) @(negedge sys_clk_i);
        check(64'({busy_o, done_o, ok_o}),
              64'({2'b01, ~^{w, p}}));
        check(64'({rx_cnt, rx_word}), 64'({4'h9, w, p}));
        $display("parity test %h/%b mode %0d done", w, p, mode);
    endtask

    initial begin
        #(25ns * 4000);
        n_errors++;
        finish_test;
    end

    initial begin
        rst_i = 1'b1;
        load_i = 1'b1;
        word_i = 8'h00;
        par_i = 1'b0;
        rx_clr = 1'b0;
        rx_mode = 2'h0;
        bcd_i = 4'h0;
        xs3_i = 4'h3;
        gray10_i = 4'h2;
        john_i = 5'h00;
        aiken_i = 4'h0;
        gray16_i = 4'h0;
        dec_n_i = 10'h3fe;
        repeat (4) @(negedge sys_clk_i);
        check(64'({ok_o, busy_o, done_o, ser_valid_o, ser_data_o}),
              64'(5'b10000));
        rst_i = 1'b0;
        $display("reset test done");
        // ************************************************************
        // Converter rows, one digit per row
        // ************************************************************
        for (int d = 0; d < 10; d++) begin
            @(negedge sys_clk_i);
            exp_n = ~(10'h001 << d);
            dec_n_i = exp_n;
            bcd_i = 4'(d);
            xs3_i = 4'(d + 3);
            gray10_i = rows[d].g10;
            john_i = rows[d].jn;
            aiken_i = rows[d].aik;
            #1;
            check(64'({bcd_dec_n_o, xs3_dec_n_o, gray_dec_n_o, john_dec_n_o}),
                  64'({4{exp_n}}));
            check(64'({john_bcd_o, gray10_bcd_o, enc_bcd_o, enc_xs3_o}),
                  64'({{3{4'(d)}}, 4'(d + 3)}));
            check(64'({enc_1242_o, enc_aiken_o, enc_john_o}),
                  64'({rows[d].c1242, rows[d].aik,
                       rows[d].jn}));
        end
        $display("converter test done");
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk_i);
            v = 4'(i);
            bcd_i = v;
            xs3_i = v;
            aiken_i = v;
            gray16_i = v ^ (v >> 1);
            #1;
            check(64'({bcd_err_o, xs3_err_o, aiken_err_o}),
                  64'({v[3] & (v[2] | v[1]), v < 4'h3 || v > 4'hc,
                       v >= 4'h5 && v <= 4'ha}));
            check(64'(gray16_bin_o), 64'(v));
        end
        $display("detector test done");
        // ************************************************************
        // Parity checker: good and bad words, slow and stalled receiver
        // ************************************************************
        run_par(8'h00, 1'b1, 2'h0);
        run_par(8'h01, 1'b0, 2'h0);
        run_par(8'hff, 1'b1, 2'h1);
        run_par(8'h80, 1'b1, 2'h0);
        run_par(8'ha5, 1'b0, 2'h2);
        // Abort mid-shift: load high returns to the preset state
        @(negedge sys_clk_i);
        word_i = 8'h3c;
        load_i = 1'b1;
        @(negedge sys_clk_i);
        load_i = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        check(64'(busy_o), 64'(1'b1));
        load_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check(64'({busy_o, done_o, ok_o}), 64'(3'b001));
        repeat (4) @(negedge sys_clk_i);
        $display("abort test done");
        run_par(8'h3c, 1'b1, 2'h0);
        finish_test;
    end
endmodule
